// file: design/gtc_pkg.sv
//==============================================================
// Behaviour
// RQ1 - 16-bit counter as readable writable byte pair
// RQ2 - wrap FFFF to 0000 sets overflow flag
// RQ3 - request needs flag and three enables
// RQ4 - flag stays until software writes zero
// RQ5 - software clears counter and flag first
// RQ6 - timer mode counts each instruction cycle
// RQ7 - counter mode counts external rising edges
// RQ8 - timer, synchronous or asynchronous counter modes
// RQ9 - falling edge needed before first rising
// RQ10 - prescale divides by 1, 2, 4, 8
// RQ11 - prescaler hidden, cleared by count write
// RQ12 - gate from pin or second comparator
// RQ13 - gate matters only when gate enabled
// RQ14 - gate invert flips either gate source
// RQ15 - asynchronous mode counts in sleep, wakes
// RQ16 - crystal oscillator may be count source
// RQ17 - run enable starts, clear holds value
// RQ18 - clock source selects instruction or external
// RQ19 - sync bit chooses synchronised or bypass
// RQ20 - gate low permits, inverted gate high
package gtc_pkg;

  //============================================================
  // register addresses
  localparam logic [2:0] ADDR_COUNT_LOW  = 3'h0;
  localparam logic [2:0] ADDR_COUNT_HIGH = 3'h1;
  localparam logic [2:0] ADDR_CONTROL    = 3'h2;
  localparam logic [2:0] ADDR_FLAG       = 3'h3;
  localparam logic [2:0] ADDR_ENABLE     = 3'h4;
  localparam logic [2:0] ADDR_IRQ_CTRL   = 3'h5;
  localparam logic [2:0] ADDR_COMP_CTRL  = 3'h6;

  //============================================================
  // field positions
  localparam int OVERFLOW_BIT      = 0;
  localparam int OVERFLOW_EN_BIT   = 0;
  localparam int GROUP_EN_BIT      = 6;
  localparam int GLOBAL_EN_BIT     = 7;
  localparam int GATE_SRC_BIT      = 1;

  //============================================================
  // reset values and counts
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  localparam logic [1:0]  INSTR_LAST_PH  = 2'h3;  // four clocks per instruction

  // control register layout, bit 7 first
  typedef struct packed {
    logic       gate_invert;
    logic       gate_enable;
    logic [1:0] prescale_select;
    logic       osc_enable;
    logic       sync_bypass;
    logic       clock_source_select;
    logic       run_enable;
  } ctrl_s;

endpackage

// file: design/gated_counter.sv
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
module gated_counter (
  input  logic       CLK,
  input  logic       ARST_N,
  input  logic [2:0] ADDR,
  input  logic [7:0] WDATA,
  input  logic       WR,
  input  logic       RD,
  output logic [7:0] RDATA,
  input  logic       EXTERNAL_COUNT_CLOCK,
  input  logic       LOW_POWER_CRYSTAL_OSC,
  input  logic       INTERNAL_OSCILLATOR_NO_CLOCK_OUTPUT,
  input  logic       GATE_PIN_N,
  input  logic       SECOND_COMPARATOR_OUTPUT,
  input  logic       SLEEP,
  output logic       IRQ,
  output logic       WAKE
);

  //==============================================================
  // registers
  gtc_pkg::ctrl_s ctrl;
  logic [15:0]    count;
  logic           overflow_flag;
  logic           overflow_enable;
  logic           peripheral_group_enable;
  logic           global_irq_enable;
  logic           gate_source_select;
  logic [1:0]     phase;
  logic [2:0]     prescale;
  logic           sync1;
  logic           sync2;
  logic           prev_src;
  logic           armed;

  logic           wr_low;
  logic           wr_high;
  logic           ext_raw;
  logic           ext_sel;
  logic           instr_tick;
  logic           rise;
  logic           fall;
  logic           source_tick;
  logic           gate_sig;
  logic           gate_ok;
  logic           running;
  logic [2:0]     pre_mask;
  logic           count_tick;
  logic           wrap;
  logic           async_mode;

  assign wr_low  = WR && (ADDR == gtc_pkg::ADDR_COUNT_LOW);
  assign wr_high = WR && (ADDR == gtc_pkg::ADDR_COUNT_HIGH);

  //==============================================================
  // count source
  // RQ16 crystal as source
  assign ext_raw = (ctrl.osc_enable && INTERNAL_OSCILLATOR_NO_CLOCK_OUTPUT) ? LOW_POWER_CRYSTAL_OSC
                                                                : EXTERNAL_COUNT_CLOCK;
  assign async_mode = ctrl.clock_source_select && ctrl.sync_bypass;

  // two-flop synchroniser for the external clock
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= ext_raw;
      sync2 <= sync1;
    end
  end

  // RQ19 sync or bypass
  assign ext_sel = ctrl.sync_bypass ? ext_raw : sync2;

  // instruction phase, stops during sleep
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase <= 2'h0;
    end else if (!SLEEP) begin
      phase <= phase + 2'h1;
    end
  end

  // RQ6 one tick per instruction
  assign instr_tick = !SLEEP && (phase == gtc_pkg::INSTR_LAST_PH);

  // previous level of the selected external clock
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prev_src <= 1'b0;
    end else begin
      prev_src <= ext_sel;
    end
  end

  assign rise = ext_sel && !prev_src;
  assign fall = !ext_sel && prev_src;

  // RQ9 arm on falling edge
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      armed <= 1'b0;
    end else if (!ctrl.run_enable || !ctrl.clock_source_select) begin
      armed <= 1'b0;
    end else if (fall) begin
      armed <= 1'b1;
    end
  end

  //==============================================================
  // mode selection
  always_comb begin
    if (!ctrl.clock_source_select) begin
      // RQ18 instruction clock
      source_tick = instr_tick;
    end else if (async_mode) begin
      // RQ15 counts during sleep
      source_tick = rise && armed;
    end else begin
      // RQ7 synchronised edges
      source_tick = rise && armed && !SLEEP;
    end
  end

  //==============================================================
  // gate
  // RQ12 gate source
  assign gate_sig = (gate_source_select ? SECOND_COMPARATOR_OUTPUT : GATE_PIN_N)
                    // RQ14 invert gate
                    ^ ctrl.gate_invert;
  // RQ13 RQ20 gate permits on low
  assign gate_ok = !ctrl.gate_enable || !gate_sig;
  // RQ17 run enable
  assign running = ctrl.run_enable && gate_ok;

  //==============================================================
  // prescaler
  // RQ10 divide select
  always_comb begin
    case (ctrl.prescale_select)
      2'h0:    pre_mask = 3'h0;
      2'h1:    pre_mask = 3'h1;
      2'h2:    pre_mask = 3'h3;
      default: pre_mask = 3'h7;
    endcase
  end

  // RQ11 clear on count write
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prescale <= 3'h0;
    end else if (wr_low || wr_high) begin
      prescale <= 3'h0;
    end else if (running && source_tick) begin
      prescale <= (prescale & pre_mask) == pre_mask ? 3'h0 : prescale + 3'h1;
    end
  end

  assign count_tick = running && source_tick && ((prescale & pre_mask) == pre_mask);
  assign wrap       = count_tick && (count == gtc_pkg::COUNT_MAX);

  //==============================================================
  // counter, software write takes priority
  // RQ1 RQ8 byte pair
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count <= gtc_pkg::COUNT_RESET;
    end else if (wr_low) begin
      count[7:0] <= WDATA;
    end else if (wr_high) begin
      count[15:8] <= WDATA;
    end else if (count_tick) begin
      count <= count + 16'h0001;
    end
  end

  //==============================================================
  // overflow flag, hardware set wins over clear
  // RQ2 RQ4 sticky flag
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (WR && ADDR == gtc_pkg::ADDR_FLAG) begin
      overflow_flag <= WDATA[gtc_pkg::OVERFLOW_BIT];
    end
  end

  // wake pulse on asynchronous overflow in sleep
  // RQ15 wake on overflow
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WAKE <= 1'b0;
    end else begin
      WAKE <= wrap && async_mode && SLEEP;
    end
  end

  // RQ3 interrupt request
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= overflow_flag && overflow_enable && peripheral_group_enable && global_irq_enable;
    end
  end

  //==============================================================
  // configuration registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl                    <= gtc_pkg::ctrl_s'(gtc_pkg::CONTROL_RESET);
      overflow_enable         <= 1'b0;
      peripheral_group_enable <= 1'b0;
      global_irq_enable       <= 1'b0;
      gate_source_select      <= 1'b0;
    end else if (WR) begin
      if (ADDR == gtc_pkg::ADDR_CONTROL) begin
        ctrl <= gtc_pkg::ctrl_s'(WDATA);
      end else if (ADDR == gtc_pkg::ADDR_ENABLE) begin
        overflow_enable <= WDATA[gtc_pkg::OVERFLOW_EN_BIT];
      end else if (ADDR == gtc_pkg::ADDR_IRQ_CTRL) begin
        peripheral_group_enable <= WDATA[gtc_pkg::GROUP_EN_BIT];
        global_irq_enable       <= WDATA[gtc_pkg::GLOBAL_EN_BIT];
      end else if (ADDR == gtc_pkg::ADDR_COMP_CTRL) begin
        gate_source_select <= WDATA[gtc_pkg::GATE_SRC_BIT];
      end
    end
  end

  //==============================================================
  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else if (!RD) begin
      RDATA <= 8'h00;
    end else if (ADDR == gtc_pkg::ADDR_COUNT_LOW) begin
      RDATA <= count[7:0];
    end else if (ADDR == gtc_pkg::ADDR_COUNT_HIGH) begin
      RDATA <= count[15:8];
    end else if (ADDR == gtc_pkg::ADDR_CONTROL) begin
      RDATA <= ctrl;
    end else if (ADDR == gtc_pkg::ADDR_FLAG) begin
      RDATA <= {7'h00, overflow_flag};
    end else if (ADDR == gtc_pkg::ADDR_ENABLE) begin
      RDATA <= {7'h00, overflow_enable};
    end else if (ADDR == gtc_pkg::ADDR_IRQ_CTRL) begin
      RDATA <= {global_irq_enable, peripheral_group_enable, 6'h00};
    end else if (ADDR == gtc_pkg::ADDR_COMP_CTRL) begin
      RDATA <= {6'h00, gate_source_select, 1'b0};
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule

// file: bench/gated_counter_monitor.sv
`timescale 1ns/100ps
module gated_counter_monitor (
  input logic       CLK,
  input logic       ARST_N,
  input logic [2:0] ADDR,
  input logic [7:0] WDATA,
  input logic       WR,
  input logic       RD,
  input logic [7:0] RDATA,
  input logic       SLEEP,
  input logic       IRQ,
  input logic       WAKE
);
  //==========================================================
  // shadow of software written control and enables
  logic [7:0] ctrl;
  logic [2:0] ens;
  // follow register writes
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl <= 8'h00;
      ens  <= 3'h0;
    end else if (WR) begin
      if (ADDR == gtc_pkg::ADDR_CONTROL) ctrl <= WDATA;
      if (ADDR == gtc_pkg::ADDR_ENABLE) ens[0] <= WDATA[0];
      if (ADDR == gtc_pkg::ADDR_IRQ_CTRL) ens[2:1] <= WDATA[7:6];
    end
  end
  //==========================================================
  // properties
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero");
  hole_read_a: assert property (RD && ADDR == 3'h7 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  ctrl_read_a: assert property (RD && ADDR == gtc_pkg::ADDR_CONTROL |=> RDATA == $past(ctrl))
    else $error("control readback wrong");
  count_write_a: assert property (WR && ADDR == 3'h0 && !ctrl[0] ##1 !WR ##1 RD && ADDR == 3'h0
    |=> RDATA == $past(WDATA, 3)) else $error("count write lost");
  count_hold_a: assert property (RD && ADDR == 3'h0 && !ctrl[0] ##1 !WR ##1 RD && ADDR == 3'h0
    |=> RDATA == $past(RDATA, 2)) else $error("stopped count moved");
  irq_enable_a: assert property (IRQ |-> $past(&ens))
    else $error("request without enables");
  irq_sticky_a: assert property (IRQ && &ens && !$past(WR && ADDR == gtc_pkg::ADDR_FLAG) |=> IRQ)
    else $error("request dropped");
  wake_cause_a: assert property (WAKE |-> $past(SLEEP) && $past(ctrl[2:1]) == 2'h3)
    else $error("wake outside async sleep");
  wake_pulse_a: assert property (WAKE |=> !WAKE)
    else $error("wake longer than one cycle");
endmodule

// file: bench/signal_source.sv
`timescale 1ns/100ps
module signal_source (
  input  logic CLK,
  output logic ext_clk,
  output logic xtal,
  output logic gate_n,
  output logic cmp_out
);
  //==========================================================
  // idle low start
  initial begin
    ext_clk = 1'b0;
    xtal    = 1'b0;
    gate_n  = 1'b0;
    cmp_out = 1'b0;
  end
  // rising edge pulses, two cycles high and low
  task automatic pulse(input int n, input logic sel);
    repeat (n) begin
      @(posedge CLK);
      if (sel) xtal <= 1'b1; else ext_clk <= 1'b1;
      repeat (2) @(posedge CLK);
      if (sel) xtal <= 1'b0; else ext_clk <= 1'b0;
      @(posedge CLK);
    end
  endtask
  // gate pin and comparator levels
  task automatic gate(input logic pin, input logic cmp);
    @(posedge CLK);
    gate_n  <= pin;
    cmp_out <= cmp;
  endtask
endmodule

// file: bench/gated_counter_bench.sv
`timescale 1ns/100ps
module gated_counter_bench;
  //==========================================================
  // stimulus and results
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        sleep = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, rdv;
  logic        ext_clk, xtal, gate_n, cmp_out, irq, wake;
  logic [31:0] seed = 32'h723E;
  logic [31:0] v;
  int          n;
  int          wakes = 0;
  int          mismatches = 0;
  int          total_checks = 0;
  // clock and wake pulse counter
  always #50 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) wakes++;
  gated_counter DUT (
    .CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .EXTERNAL_COUNT_CLOCK(ext_clk), .LOW_POWER_CRYSTAL_OSC(xtal), .INTERNAL_OSCILLATOR_NO_CLOCK_OUTPUT(1'b1),
    .GATE_PIN_N(gate_n), .SECOND_COMPARATOR_OUTPUT(cmp_out), .SLEEP(sleep), .IRQ(irq), .WAKE(wake)
  );
  signal_source src (
    .CLK(clk), .ext_clk(ext_clk), .xtal(xtal), .gate_n(gate_n), .cmp_out(cmp_out)
  );
  //==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // increments over 16 timer ticks, none while the gate is shut
  function automatic logic [7:0] exp_count(input logic [7:0] c, input logic lvl);
    if (c[6] && (lvl ^ c[7])) return 8'h00;
    return 8'h10 >> c[5:4];
  endfunction
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 rdv = rdata;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input string what, input logic [2:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(what, exp, rdv);
  endtask
  // run the timer for exactly 64 clocks, then read the low byte
  task automatic timed(input logic [7:0] c, input logic lvl);
    bus(1'b1, 3'h0, 8'h00);
    bus(1'b1, 3'h2, c);
    repeat (62) @(posedge clk);
    bus(1'b1, 3'h2, 8'h00);
    rdchk("timed count", 3'h0, exp_count(c, lvl));
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  //==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b1, 3'h7, 8'hFF);
    for (int a = 0; a < 8; a++) rdchk("reset value", a[2:0], 8'h00);
    repeat (4) begin
      v = rnd();
      bus(1'b1, 3'h0, v[7:0]);
      rdchk("count low", 3'h0, v[7:0]);
      rdchk("count hold", 3'h0, v[7:0]);
      bus(1'b1, 3'h1, v[15:8]);
      rdchk("count high", 3'h1, v[15:8]);
    end
    src.gate(1'b1, 1'b1);
    for (int p = 0; p < 4; p++) timed({2'h0, p[1:0], 4'h1}, 1'b1);
    for (int g = 0; g < 8; g++) begin
      bus(1'b1, 3'h6, {6'h00, g[1], 1'b0});
      src.gate(g[0] ^ g[1], !(g[0] ^ g[1]));
      timed({g[2], 7'h41}, g[0]);
    end
    bus(1'b1, 3'h6, 8'h00);
    for (int m = 0; m < 3; m++) begin
      n = 3 + rnd() % 6;
      bus(1'b1, 3'h0, 8'h00);
      bus(1'b1, 3'h2, m == 0 ? 8'h03 : m == 1 ? 8'h07 : 8'h0B);
      src.pulse(n, m == 2);
      bus(1'b1, 3'h2, 8'h00);
      rdchk("edge count", 3'h0, 8'(n - 1));
    end
    bus(1'b1, 3'h0, 8'hFF);
    bus(1'b1, 3'h1, 8'hFF);
    bus(1'b1, 3'h3, 8'h00);
    bus(1'b1, 3'h4, 8'h01);
    bus(1'b1, 3'h5, 8'hC0);
    bus(1'b1, 3'h2, 8'h01);
    repeat (2) @(posedge clk);
    bus(1'b1, 3'h2, 8'h00);
    @(posedge clk);
    #1 check("irq", 8'h01, {7'h00, irq});
    rdchk("flag", 3'h3, 8'h01);
    rdchk("wrapped", 3'h1, 8'h00);
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 3'h4, {7'h00, m[0]});
      bus(1'b1, 3'h5, {m[2:1], 6'h00});
      @(posedge clk);
      #1 check("irq mask", {7'h00, m == 7}, {7'h00, irq});
    end
    bus(1'b1, 3'h3, 8'h00);
    @(posedge clk);
    #1 check("irq cleared", 8'h00, {7'h00, irq});
    bus(1'b1, 3'h0, 8'hFF);
    bus(1'b1, 3'h1, 8'hFF);
    @(posedge clk);
    sleep <= 1'b1;
    bus(1'b1, 3'h2, 8'h07);
    src.pulse(2, 1'b0);
    bus(1'b1, 3'h2, 8'h00);
    check("wake pulses", 8'h01, wakes[7:0]);
    results();
  end
  // watchdog, far beyond the little over a thousand clocks the run needs
  initial begin
    #5000000;
    mismatches++;
    results();
  end
endmodule
bind gated_counter gated_counter_monitor mon (
  .CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .SLEEP(SLEEP), .IRQ(IRQ), .WAKE(WAKE)
);
